// file: rtl/mwdec_pkg.sv
// Constants for the window bank decoder and chip select ranking
// What this block does
// - Each window starts on a boundary of its own size, except a 32K window at 0x4000.
// - Window base holds three top address bits per window.
// - Lowest base bit is ignored for 16K and 32K windows.
// - 32K bases: 000/001 at zero, 010/011 at 0x4000, 1xx at 0x8000.
// - Inside window 1, its bank value drives all six expansion lines for 8K, the top five for 16K and the top four for 32K.
// - Inside window 2 only, window 2 bank value drives the lines.
// - A newly written bank value is used for following window accesses.
// - Window 1 wins where windows overlap.
// - On-chip registers, RAM and EEPROM override any window.
// - Unimplemented bits of base, bank and pin registers read zero.
// - Each pin assignment bit makes its pin an expansion address line.
// - An assigned low line unused by any window carries the CPU address bit.
// - An enabled select asserts while the CPU addresses its range.
// - Selects are timed by the E clock, which may be stretched.
// - Four selects work only in expanded modes; else pins are plain I/O.
// - Priority bit clear: internal, I/O, program, general 1, general 2.
// - Priority bit set: general selects rank above program select.
// - Normal expanded reset enables program select without internal vector memory.
// - Program stretch resets to one in normal mode, zero in test.
// - Program select uses address-valid timing and is active low.
// - I/O select covers 0x1000-0x1FFF or 0x0000-0x1FFF.
// - I/O select has programmable polarity and zero to three stretch cycles.
// - Size field: 00 off, 01 8K, 10 16K, 11 32K.
// - 32K window at 0x4000 drives inverted address bit 14 while active.
package mwdec_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_PIN_ASSIGN = 8'h2d;
  localparam logic [7:0] IDX_WIN_SIZE   = 8'h56;
  localparam logic [7:0] IDX_WIN_BASE   = 8'h57;
  localparam logic [7:0] IDX_WIN1_BANK  = 8'h58;
  localparam logic [7:0] IDX_WIN2_BANK  = 8'h59;
  localparam logic [7:0] IDX_STRETCH    = 8'h5a;
  localparam logic [7:0] IDX_SEL_CTRL   = 8'h5b;
  localparam int         APB_AW         = 10;
  // Implemented bit masks
  localparam logic [7:0] MASK_PIN_ASSIGN = 8'h3f;
  localparam logic [7:0] MASK_WIN_SIZE   = 8'hf3;
  localparam logic [7:0] MASK_WIN_BASE   = 8'hee;
  localparam logic [7:0] MASK_BANK       = 8'h7e;
  localparam logic [7:0] MASK_STRETCH    = 8'h0f;
  localparam logic [7:0] MASK_SEL_CTRL   = 8'hff;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  // Field positions
  localparam int SZ_W1_LSB = 0;
  localparam int SZ_W2_LSB = 4;
  localparam int WB_W1_LSB = 1;
  localparam int WB_W2_LSB = 5;
  localparam int BANK_LSB  = 1;
  localparam int ST_IO_LSB = 0;
  localparam int ST_PR_LSB = 2;
  localparam int CTL_IO_ON     = 7;
  localparam int CTL_IO_HIGH   = 6;
  localparam int CTL_IO_AV     = 5;
  localparam int CTL_IO_8K     = 4;
  localparam int CTL_GP_FIRST  = 3;
  localparam int CTL_PROG_ON   = 2;
  localparam int CTL_PROG_SIZE = 0;
  // Window size codes
  localparam logic [1:0] SZ_OFF = 2'h0;
  localparam logic [1:0] SZ_8K  = 2'h1;
  localparam logic [1:0] SZ_16K = 2'h2;
  localparam logic [1:0] SZ_32K = 2'h3;
  // Reset stretch of the program select
  localparam logic [1:0] PROG_ST_NORMAL = 2'h1;
  localparam logic [1:0] PROG_ST_TEST   = 2'h0;
  // E clock half period in clk cycles
  localparam logic [7:0] E_HALF_CLKS = 8'h04;
  localparam logic [1:0] INIT_LOAD   = 2'h2;
  typedef enum logic {PHASE_LOW, PHASE_HIGH} e_phase_type;
endpackage

// file: rtl/memory_window_chip_select_decode.sv
// Window bank decode, pin assignment and chip select ranking
`timescale 1ns/10ps
module memory_window_chip_select_decode #(
  parameter logic [7:0] E_HALF = mwdec_pkg::E_HALF_CLKS
) (
  // Clock and reset
  input  logic                          clk,
  input  logic                          rst,
  // APB slave
  input  logic                          psel,
  input  logic                          penable,
  input  logic                          pwrite,
  input  logic [mwdec_pkg::APB_AW-1:0]  paddr,
  input  logic [31:0]                   pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Mode straps from pins
  input  logic                          expanded_mode,
  input  logic                          special_test_mode,
  input  logic                          vector_internal,
  // CPU core side
  input  logic [15:0]                   cpu_addr,
  input  logic                          cpu_access,
  input  logic                          internal_hit,
  input  logic                          gp1_hit,
  input  logic                          gp2_hit,
  // Bus timing
  output logic                          e_clk,
  output logic                          cpu_wait,
  // Expansion address pins
  output logic [5:0]                    expansion_address_lines,
  output logic [5:0]                    expansion_address_enable,
  // Chip select pins
  output logic                          io_select,
  output logic                          io_select_enable,
  output logic                          program_select_n,
  output logic                          program_select_enable,
  output logic                          general_select_1,
  output logic                          general_select_2
);

  ////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] port_pin_assignment;
  logic [7:0] window_size_register;
  logic [7:0] window_base;
  logic [7:0] window1_bank;
  logic [7:0] window2_bank;
  logic [7:0] select_stretch_control;
  logic [7:0] select_control;

  ////////////////////////////////////////////////////////////////
  // Strap synchroniser and post-reset load
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [1:0] init_cnt;

  // Two flops per strap, then a load counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      init_cnt   <= 2'h0;
    end else begin
      strap_meta <= {vector_internal, special_test_mode, expanded_mode};
      strap_sync <= strap_meta;
      if (init_cnt != 2'h3) begin
        init_cnt <= init_cnt + 2'h1;
      end
    end
  end

  // Synchronised mode levels
  wire exp_mode  = strap_sync[0];
  wire test_mode = strap_sync[1];
  wire vec_int   = strap_sync[2];
  wire init_load = init_cnt == mwdec_pkg::INIT_LOAD;

  ////////////////////////////////////////////////////////////////
  // APB decode
  wire       access  = psel && penable;
  wire [7:0] idx     = paddr[9:2];
  wire       aligned = paddr[1:0] == 2'h0;
  wire       sel_pin = idx == mwdec_pkg::IDX_PIN_ASSIGN;
  wire       sel_sz  = idx == mwdec_pkg::IDX_WIN_SIZE;
  wire       sel_wb  = idx == mwdec_pkg::IDX_WIN_BASE;
  wire       sel_w1  = idx == mwdec_pkg::IDX_WIN1_BANK;
  wire       sel_w2  = idx == mwdec_pkg::IDX_WIN2_BANK;
  wire       sel_st  = idx == mwdec_pkg::IDX_STRETCH;
  wire       sel_ctl = idx == mwdec_pkg::IDX_SEL_CTRL;
  wire       mapped  = aligned && (sel_pin || sel_sz || sel_wb || sel_w1 ||
                                   sel_w2 || sel_st || sel_ctl);
  wire       wr_fire = access && pready && pwrite && mapped;
  wire [7:0] wdat    = pwdata[7:0];

  // Read mux; stored values already hold zeros in unused bits
  wire [7:0] rd_mux = ({8{sel_pin}} & port_pin_assignment) |
                      ({8{sel_sz}} & window_size_register) |
                      ({8{sel_wb}} & window_base) |
                      ({8{sel_w1}} & window1_bank) |
                      ({8{sel_w2}} & window2_bank) |
                      ({8{sel_st}} & select_stretch_control) |
                      ({8{sel_ctl}} & select_control);

  // One wait state, then answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata  <= (access && !pready && mapped) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Window and pin registers
  // zero reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_pin_assignment  <= mwdec_pkg::RST_ZERO;
      window_size_register <= mwdec_pkg::RST_ZERO;
      window_base          <= mwdec_pkg::RST_ZERO;
      window1_bank         <= mwdec_pkg::RST_ZERO;
      window2_bank         <= mwdec_pkg::RST_ZERO;
    end else if (wr_fire) begin
      if (sel_pin) port_pin_assignment <= wdat & mwdec_pkg::MASK_PIN_ASSIGN;
      if (sel_sz) window_size_register <= wdat & mwdec_pkg::MASK_WIN_SIZE;
      if (sel_wb) window_base <= wdat & mwdec_pkg::MASK_WIN_BASE;
      if (sel_w1) window1_bank <= wdat & mwdec_pkg::MASK_BANK;
      if (sel_w2) window2_bank <= wdat & mwdec_pkg::MASK_BANK;
    end
  end

  // Select control and stretch, loaded from straps after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      select_control         <= mwdec_pkg::RST_ZERO;
      select_stretch_control <= mwdec_pkg::RST_ZERO;
    end else if (init_load) begin
      select_control[mwdec_pkg::CTL_PROG_ON] <= exp_mode && (test_mode || !vec_int);
      select_stretch_control[mwdec_pkg::ST_PR_LSB +: 2] <=
        test_mode ? mwdec_pkg::PROG_ST_TEST : mwdec_pkg::PROG_ST_NORMAL;
    end else if (wr_fire) begin
      if (sel_ctl) select_control <= wdat & mwdec_pkg::MASK_SEL_CTRL;
      if (sel_st) select_stretch_control <= wdat & mwdec_pkg::MASK_STRETCH;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Window hit detection
  // masked compare, disabled never hits
  function automatic logic win_hit(input logic [2:0] a, input logic [2:0] b,
                                   input logic [1:0] sz);
    case (sz)
      mwdec_pkg::SZ_8K:  win_hit = a == b;
      mwdec_pkg::SZ_16K: win_hit = a[2:1] == b[2:1];
      // 32K bases at 0, 0x4000, 0x8000
      mwdec_pkg::SZ_32K: win_hit = b[2] ? a[2] : (b[1] ? (a[2] ^ a[1]) : !a[2]);
      default:           win_hit = 1'b0;
    endcase
  endfunction

  logic [2:0] wbase [2];
  logic [1:0] wsize [2];
  logic [5:0] wbank [2];
  logic [1:0] whit;
  assign wbase[0] = window_base[mwdec_pkg::WB_W1_LSB +: 3];
  assign wbase[1] = window_base[mwdec_pkg::WB_W2_LSB +: 3];
  assign wsize[0] = window_size_register[mwdec_pkg::SZ_W1_LSB +: 2];
  assign wsize[1] = window_size_register[mwdec_pkg::SZ_W2_LSB +: 2];
  assign wbank[0] = window1_bank[mwdec_pkg::BANK_LSB +: 6];
  assign wbank[1] = window2_bank[mwdec_pkg::BANK_LSB +: 6];

  // Per-window compare
  for (genvar w = 0; w < 2; w++) begin : g_win
    assign whit[w] = win_hit(cpu_addr[15:13], wbase[w], wsize[w]);
  end

  wire open_bus = cpu_access && !internal_hit;
  wire w1_act   = open_bus && whit[0];
  wire w2_act   = open_bus && whit[1] && !whit[0];
  wire any_act  = w1_act || w2_act;

  wire [5:0] act_bank = w1_act ? wbank[0] : wbank[1];
  wire [1:0] act_size = w1_act ? wsize[0] : wsize[1];
  wire [2:0] act_base = w1_act ? wbase[0] : wbase[1];
  wire [2:0] act_lsb  = (act_size == mwdec_pkg::SZ_8K)  ? 3'h0 :
                        (act_size == mwdec_pkg::SZ_16K) ? 3'h1 : 3'h2;
  wire       mid_32k  = any_act && act_size == mwdec_pkg::SZ_32K && act_base[2:1] == 2'h1;

  ////////////////////////////////////////////////////////////////
  // Expansion line values
  logic [5:0] next_xa;
  for (genvar i = 0; i < 6; i++) begin : g_xa
    wire uses = any_act && (3'(i) >= act_lsb);
    if (i == 1) begin : g_mid
      assign next_xa[i] = mid_32k ? !cpu_addr[14] : (uses ? act_bank[i] : cpu_addr[14]);
    end else if (i < 3) begin : g_low
      // unused low line carries CPU bit
      assign next_xa[i] = uses ? act_bank[i] : cpu_addr[13+i];
    end else begin : g_high
      // Idle upper lines sit high
      assign next_xa[i] = uses ? act_bank[i] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Chip select ranges
  wire       cs_open  = open_bus && exp_mode;
  wire       io_av    = select_control[mwdec_pkg::CTL_IO_AV];
  wire       io_pol   = select_control[mwdec_pkg::CTL_IO_HIGH];
  wire [1:0] pcsz     = select_control[mwdec_pkg::CTL_PROG_SIZE +: 2];
  wire       gp_first = select_control[mwdec_pkg::CTL_GP_FIRST];
  wire       io_range = select_control[mwdec_pkg::CTL_IO_8K] ?
                        (cpu_addr[15:13] == 3'h0) : (cpu_addr[15:12] == 4'h1);
  wire       pr_range = (pcsz == 2'h0) ||
                        (pcsz == 2'h1 && cpu_addr[15]) ||
                        (pcsz == 2'h2 && cpu_addr[15:14] == 2'h3) ||
                        (pcsz == 2'h3 && cpu_addr[15:13] == 3'h7);

  // enabled select in range, expanded only
  wire io_req = cs_open && select_control[mwdec_pkg::CTL_IO_ON] && io_range;
  wire pr_req = cs_open && select_control[mwdec_pkg::CTL_PROG_ON] && pr_range;
  wire g1_req = cs_open && gp1_hit;
  wire g2_req = cs_open && gp2_hit;

  wire win_io = io_req;
  wire win_pr = pr_req && !io_req && !(gp_first && (g1_req || g2_req));
  wire win_g1 = g1_req && !io_req && !(!gp_first && pr_req);
  wire win_g2 = g2_req && !io_req && !g1_req && !(!gp_first && pr_req);

  wire [1:0] win_st = win_io ? select_stretch_control[mwdec_pkg::ST_IO_LSB +: 2] :
                      win_pr ? select_stretch_control[mwdec_pkg::ST_PR_LSB +: 2] : 2'h0;

  ////////////////////////////////////////////////////////////////
  // E clock sequencing
  mwdec_pkg::e_phase_type phase;
  mwdec_pkg::e_phase_type next_phase;
  logic [7:0] e_cnt;
  logic [2:0] st_left;
  logic [2:0] next_st_left;
  logic [3:0] cyc;
  logic [3:0] next_cyc;

  wire e_tick  = e_cnt == E_HALF - 8'h01;
  wire falling = e_tick && phase == mwdec_pkg::PHASE_HIGH && st_left == 3'h0;

  // high phase held two ticks per stretch cycle
  always_comb begin
    next_phase   = phase;
    next_st_left = st_left;
    case (phase)
      mwdec_pkg::PHASE_LOW: begin
        if (e_tick) next_phase = mwdec_pkg::PHASE_HIGH;
      end
      mwdec_pkg::PHASE_HIGH: begin
        if (e_tick && st_left != 3'h0) begin
          next_st_left = st_left - 3'h1;
        end else if (e_tick) begin
          next_phase   = mwdec_pkg::PHASE_LOW;
          next_st_left = {win_st, 1'b0};
        end
      end
      default: next_phase = mwdec_pkg::PHASE_LOW;
    endcase
  end

  // Decode latched at each falling E edge
  assign next_cyc = falling ? {win_io, win_pr, win_g1, win_g2} : cyc;

  // Divider and phase state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e_cnt   <= 8'h00;
      phase   <= mwdec_pkg::PHASE_LOW;
      st_left <= 3'h0;
      cyc     <= 4'h0;
    end else begin
      e_cnt   <= e_tick ? 8'h00 : e_cnt + 8'h01;
      phase   <= next_phase;
      st_left <= next_st_left;
      cyc     <= next_cyc;
    end
  end

  // I/O select window: address valid or E high
  wire e_next_high = next_phase == mwdec_pkg::PHASE_HIGH;
  wire io_on       = next_cyc[3] && exp_mode && (io_av || e_next_high);

  ////////////////////////////////////////////////////////////////
  // Registered pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e_clk                    <= 1'b0;
      cpu_wait                 <= 1'b0;
      expansion_address_lines  <= 6'h3f;
      expansion_address_enable <= 6'h00;
      io_select                <= 1'b1;
      io_select_enable         <= 1'b0;
      program_select_n         <= 1'b1;
      program_select_enable    <= 1'b0;
      general_select_1         <= 1'b0;
      general_select_2         <= 1'b0;
    end else begin
      e_clk                    <= e_next_high;
      cpu_wait                 <= e_next_high && next_st_left != 3'h0;
      expansion_address_lines  <= next_xa;
      expansion_address_enable <= port_pin_assignment[5:0];
      io_select                <= io_pol ? io_on : !io_on;
      io_select_enable         <= exp_mode && select_control[mwdec_pkg::CTL_IO_ON];
      program_select_n         <= !(next_cyc[2] && exp_mode);
      program_select_enable    <= exp_mode && select_control[mwdec_pkg::CTL_PROG_ON];
      general_select_1         <= next_cyc[1] && exp_mode;
      general_select_2         <= next_cyc[0] && exp_mode;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_w1_write;
    wr_fire && sel_w1;
  endsequence

  sequence s_pin_write;
    wr_fire && sel_pin;
  endsequence

  property p_win1_bank;
    w1_act && wsize[0] == mwdec_pkg::SZ_8K |=> expansion_address_lines == $past(wbank[0]);
  endproperty
  a_win1_bank: assert property (p_win1_bank) else $error("window 1 bank not driven");

  property p_win2_bank;
    w2_act && wsize[1] == mwdec_pkg::SZ_8K |=> expansion_address_lines == $past(wbank[1]);
  endproperty
  a_win2_bank: assert property (p_win2_bank) else $error("window 2 bank not driven");

  property p_overlap;
    open_bus && whit[0] && whit[1] |=> expansion_address_lines[5:3] == $past(wbank[0][5:3]);
  endproperty
  a_overlap: assert property (p_overlap) else $error("window 2 won an overlap");

  property p_internal;
    cpu_access && internal_hit |=> expansion_address_lines[5:3] == 3'h7;
  endproperty
  a_internal: assert property (p_internal) else $error("window active over internal");

  property p_unused_low;
    cpu_access && whit == 2'h0 |=> expansion_address_lines[2:0] == $past(cpu_addr[15:13]);
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("cpu bit not on free line");

  property p_mid32k;
    mid_32k |=> expansion_address_lines[1] == !$past(cpu_addr[14]);
  endproperty
  a_mid32k: assert property (p_mid32k) else $error("bit 14 not inverted");

  property p_new_bank;
    s_w1_write ##1 (open_bus && whit[0] && wsize[0] == mwdec_pkg::SZ_8K) |=>
      expansion_address_lines == $past(pwdata[6:1], 2);
  endproperty
  a_new_bank: assert property (p_new_bank) else $error("stale bank used");

  property p_pin_assign;
    s_pin_write |=> ##1 expansion_address_enable == $past(pwdata[5:0], 2);
  endproperty
  a_pin_assign: assert property (p_pin_assign) else $error("pin assignment ignored");

  property p_read_zero;
    pready && !pwrite && $past(sel_wb && aligned) |-> (prdata & 32'h0000_ff11) == 32'h0000_0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unused base bits read set");

  property p_prio_clear;
    falling && !gp_first && pr_req && g1_req && !io_req |=> !program_select_n && !general_select_1;
  endproperty
  a_prio_clear: assert property (p_prio_clear) else $error("program select lost rank");

  property p_prio_set;
    falling && gp_first && pr_req && g1_req && !io_req |=> program_select_n && general_select_1;
  endproperty
  a_prio_set: assert property (p_prio_set) else $error("general select lost rank");

  property p_prog_timing;
    $fell(program_select_n) |-> !e_clk;
  endproperty
  a_prog_timing: assert property (p_prog_timing) else $error("program select off cycle");

  property p_strap;
    init_load && exp_mode && !test_mode && !vec_int |=>
      select_control[mwdec_pkg::CTL_PROG_ON] && select_stretch_control[3:2] == 2'h1;
  endproperty
  a_strap: assert property (p_strap) else $error("program select reset state wrong");

  property p_expanded;
    !exp_mode |=> program_select_n && !general_select_1 && !general_select_2;
  endproperty
  a_expanded: assert property (p_expanded) else $error("select outside expanded mode");

endmodule

// file: verification/ext_bus_model.sv
// External memory partner that latches program memory addresses
`timescale 1ns/10ps
module ext_bus_model (
  // Bus side
  input  wire logic        clk,
  input  wire logic        program_select_n,
  input  wire logic [5:0]  lines,
  input  wire logic [15:0] cpu_addr,
  // Observation
  output logic      [18:0] last_addr
);
  // Capture the full expanded address while selected
  always_ff @(posedge clk) begin
    if (!program_select_n) begin
      last_addr <= {lines, cpu_addr[12:0]};
    end
  end
endmodule

// file: verification/memory_window_chip_select_decode_test.sv
// Testbench for window decode and chip select ranking
`timescale 1ns/10ps
module memory_window_chip_select_decode_test;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, e_clk, cpu_wait, io_select, io_select_enable;
  logic        program_select_n, program_select_enable, general_select_1, general_select_2;
  logic [15:0] cpu_addr = 16'h0000;
  logic        cpu_access = 1'b1, internal_hit = 1'b0, gp1_hit = 1'b0, gp2_hit = 1'b0;
  logic        exp_strap = 1'b1, test_strap = 1'b0;
  logic [5:0]  expansion_address_lines, expansion_address_enable;
  logic [18:0] last_addr;
  int          n_mismatch = 0, checked = 0, cycles = 0, n_wait = 0, w_start = 0;
  logic [7:0]  ridx [4] = '{mwdec_pkg::IDX_PIN_ASSIGN, mwdec_pkg::IDX_WIN_BASE,
                            mwdec_pkg::IDX_WIN1_BANK, mwdec_pkg::IDX_WIN2_BANK};
  logic [7:0]  rmsk [4] = '{8'h3f, 8'hee, 8'h7e, 8'h7e};

  memory_window_chip_select_decode #(.E_HALF(8'h02)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .expanded_mode(exp_strap), .special_test_mode(test_strap), .vector_internal(1'b0),
    .cpu_addr(cpu_addr), .cpu_access(cpu_access), .internal_hit(internal_hit),
    .gp1_hit(gp1_hit), .gp2_hit(gp2_hit), .e_clk(e_clk), .cpu_wait(cpu_wait),
    .expansion_address_lines(expansion_address_lines),
    .expansion_address_enable(expansion_address_enable), .io_select(io_select),
    .io_select_enable(io_select_enable), .program_select_n(program_select_n),
    .program_select_enable(program_select_enable), .general_select_1(general_select_1),
    .general_select_2(general_select_2));
  ext_bus_model model (.clk(clk), .program_select_n(program_select_n),
    .lines(expansion_address_lines), .cpu_addr(cpu_addr), .last_addr(last_addr));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Cycles seen with the wait output high
  always @(negedge clk) begin
    if (cpu_wait === 1'b1) n_wait++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task complete_run();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Compare and count
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // One APB transfer, request held until pready
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Program both windows, present an address, check the lines
  task win(input logic [7:0] sz, wb, b1, b2, input logic [15:0] a, input logic ih,
           input logic [5:0] exp);
    apb(1'b1, mwdec_pkg::IDX_WIN_SIZE, sz);
    apb(1'b1, mwdec_pkg::IDX_WIN_BASE, wb);
    apb(1'b1, mwdec_pkg::IDX_WIN1_BANK, b1);
    apb(1'b1, mwdec_pkg::IDX_WIN2_BANK, b2);
    cpu_addr <= a;
    internal_hit <= ih;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("lines", {26'h0, exp}, {26'h0, expansion_address_lines});
    chk("pin enables", 32'h0000_002a, {26'h0, expansion_address_enable});
    @(posedge clk);
  endtask

  // Set select control, run two E cycles, check io, program, general selects
  task sel(input logic [7:0] ctl, input logic [15:0] a, input logic ih, g1, g2,
           input logic [3:0] exp);
    apb(1'b1, mwdec_pkg::IDX_SEL_CTRL, ctl);
    cpu_addr <= a;
    internal_hit <= ih;
    gp1_hit <= g1;
    gp2_hit <= g2;
    repeat (2) @(negedge e_clk);
    @(negedge clk);
    chk("selects", {28'h0, exp},
        {28'h0, io_select, program_select_n, general_select_1, general_select_2});
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, mwdec_pkg::IDX_SEL_CTRL, 8'h00);
    chk("select control", 32'h0000_0004, rd);
    apb(1'b0, mwdec_pkg::IDX_STRETCH, 8'h00);
    chk("stretch", 32'h0000_0004, rd);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      chk("reset value", 32'h0000_0000, rd);
      apb(1'b1, ridx[i], 8'hff);
      apb(1'b0, ridx[i], 8'h00);
      chk("masked read", {24'h00_0000, rmsk[i]}, rd);
    end
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    apb(1'b1, mwdec_pkg::IDX_PIN_ASSIGN, 8'h2a);
    $display("test registers done");
    win(8'h01, 8'h04, 8'h2a, 8'h00, 16'h4123, 1'b0, 6'h15);
    win(8'h01, 8'h04, 8'h2a, 8'h00, 16'h6000, 1'b0, 6'h3b);
    win(8'h01, 8'h04, 8'h58, 8'h00, 16'h4123, 1'b0, 6'h2c);
    win(8'h01, 8'h04, 8'h58, 8'h00, 16'h4123, 1'b1, 6'h3a);
    win(8'h21, 8'h64, 8'h2a, 8'h64, 16'h4000, 1'b0, 6'h15);
    win(8'h21, 8'h64, 8'h2a, 8'h64, 16'h6001, 1'b0, 6'h33);
    win(8'h30, 8'h60, 8'h00, 8'h58, 16'h6000, 1'b0, 6'h2d);
    win(8'h30, 8'h60, 8'h00, 8'h58, 16'hc000, 1'b0, 6'h3e);
    win(8'h00, 8'h60, 8'h00, 8'h58, 16'h6000, 1'b0, 6'h3b);
    $display("test windows done");
    sel(8'he4, 16'h1800, 1'b0, 1'b0, 1'b0, 4'b1100);
    sel(8'he4, 16'h0800, 1'b0, 1'b0, 1'b0, 4'b0000);
    sel(8'hf4, 16'h0800, 1'b0, 1'b0, 1'b0, 4'b1100);
    apb(1'b1, mwdec_pkg::IDX_STRETCH, 8'h03);
    sel(8'ha4, 16'h1800, 1'b0, 1'b0, 1'b0, 4'b0100);
    w_start = n_wait;
    @(negedge e_clk);
    chk("wait cycles", 32'h0000_000c, n_wait - w_start);
    sel(8'he4, 16'h8000, 1'b0, 1'b1, 1'b0, 4'b0000);
    sel(8'hec, 16'h8000, 1'b0, 1'b1, 1'b0, 4'b0110);
    sel(8'hec, 16'h8000, 1'b0, 1'b0, 1'b1, 4'b0101);
    sel(8'he4, 16'h8000, 1'b1, 1'b0, 1'b0, 4'b0100);
    chk("partner address", 32'h0007_8000, {13'h0, last_addr});
    chk("select enables", 32'h0000_0003,
        {30'h0, io_select_enable, program_select_enable});
    $display("test selects done");
    rst <= 1'b1;
    test_strap <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, mwdec_pkg::IDX_SEL_CTRL, 8'h00);
    chk("test select control", 32'h0000_0004, rd);
    apb(1'b0, mwdec_pkg::IDX_STRETCH, 8'h00);
    chk("test stretch", 32'h0000_0000, rd);
    exp_strap <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("plain mode enables", 32'h0000_0000,
        {30'h0, io_select_enable, program_select_enable});
    $display("test modes done");
    complete_run();
  end
endmodule
